// ===== hdl/astr_router.sv
// converter start trigger router: direct multifunction timer path and
// event link path for pwm timer requests, apb register slave
// assumes all trigger inputs are one-cycle pulses on clk_sys
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module astr_router
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ch4_trigger_a,
	input  wire logic        ch4_trigger_b,
	input  wire logic        ch4_trigger_both,
	input  wire logic        ch7_trigger_a,
	input  wire logic        ch7_trigger_b,
	input  wire logic        ch7_trigger_both,
	input  wire logic [9:0]  pwm_req_a,
	input  wire logic [9:0]  pwm_req_b,
	output logic      [2:0]  unit_sync_trigger,
	output logic      [2:0]  unit_link_trigger0,
	output logic      [2:0]  unit_link_trigger1,
	output logic      [2:0]  unit_start
);
	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	logic [7:0]  sel [astr_pkg::NUM_SEL];  // event_route_selector, event_code_field
	logic [1:0]  converter_control_reg;
	logic [19:0] conv_request_enable_reg;  // b in [19:10], a in [9:0]
	logic        extended_skip_link_reg;
	logic [5:0]  src_sel;                  // 2 bits per unit
	logic [5:0]  link_pulse;
	logic [2:0]  sync_pulse;

	wire         wr_acc  = psel & penable & pwrite & clk_en;
	wire         in_sel  = paddr < astr_pkg::ADDR_CONV_CTL && paddr[1:0] == 2'b00;
	wire [2:0]   sel_idx = paddr[4:2];
	wire         mapped  = in_sel || paddr == astr_pkg::ADDR_CONV_CTL
		|| paddr == astr_pkg::ADDR_REQ_EN || paddr == astr_pkg::ADDR_SKIP
		|| paddr == astr_pkg::ADDR_SRC_SEL || paddr == astr_pkg::ADDR_STATUS;
	wire         sync_mode = converter_control_reg[astr_pkg::CTL_START_BIT]
		& ~converter_control_reg[astr_pkg::CTL_ASYNC_BIT]; // see R3

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// register writes
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < astr_pkg::NUM_SEL; i++)
				sel[i] <= astr_pkg::SEL_RESET;
			converter_control_reg   <= astr_pkg::CTL_RESET;
			conv_request_enable_reg <= astr_pkg::REQ_EN_RESET;
			extended_skip_link_reg  <= astr_pkg::SKIP_RESET;
			src_sel                 <= astr_pkg::SRC_SEL_RESET;
		end
		else if (wr_acc && mapped)
		begin
			if (in_sel)
				sel[sel_idx] <= pwdata[7:0]; // see R6
			if (paddr == astr_pkg::ADDR_CONV_CTL)
				converter_control_reg <= pwdata[1:0];
			if (paddr == astr_pkg::ADDR_REQ_EN)
				conv_request_enable_reg <= pwdata[19:0];
			if (paddr == astr_pkg::ADDR_SKIP)
				extended_skip_link_reg <= pwdata[0];
			if (paddr == astr_pkg::ADDR_SRC_SEL)
				src_sel <= pwdata[5:0];
		end
	end

	// read data, registered
	logic [31:0] rd_word;
	always_comb
	begin
		rd_word = 32'h00000000;
		if (in_sel)
			rd_word = {24'h0, sel[sel_idx]};
		else if (paddr == astr_pkg::ADDR_CONV_CTL)
			rd_word = {30'h0, converter_control_reg};
		else if (paddr == astr_pkg::ADDR_REQ_EN)
			rd_word = {12'h0, conv_request_enable_reg};
		else if (paddr == astr_pkg::ADDR_SKIP)
			rd_word = {31'h0, extended_skip_link_reg};
		else if (paddr == astr_pkg::ADDR_SRC_SEL)
			rd_word = {26'h0, src_sel};
		else if (paddr == astr_pkg::ADDR_STATUS)
			rd_word = {22'h0, sync_mode, sync_pulse, link_pulse};
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			prdata <= 32'h00000000;
		else if (clk_en && psel && !penable)
			prdata <= rd_word;
	end

	// --------------------------------------------------------------
	// event link path: code decode per selector
	// --------------------------------------------------------------
	logic [5:0] link_hit;
	genvar g;
	generate
		for (g = 0; g < astr_pkg::NUM_SEL; g++)
		begin : g_sel
			logic hit;
			always_comb
			begin
				hit = 1'b0;
				for (int c = 0; c < astr_pkg::NUM_PWM; c++)
				begin
					// see R7
					if (sel[g] == 8'(astr_pkg::CODE_BASE_A + 8'(c) * astr_pkg::CODE_STEP))
						hit = pwm_req_a[c] & (~extended_skip_link_reg
							| conv_request_enable_reg[c]); // see R9
					if (sel[g] == 8'(astr_pkg::CODE_BASE_B + 8'(c) * astr_pkg::CODE_STEP))
						hit = pwm_req_b[c] & (~extended_skip_link_reg
							| conv_request_enable_reg[10 + c]); // see R9
				end
			end
			assign link_hit[g] = hit; // see R2
		end
	endgenerate

	// --------------------------------------------------------------
	// direct path: channel 4 to unit 0, channel 7 to unit 1 and 2
	// --------------------------------------------------------------
	logic [2:0] direct_hit;
	generate
		for (g = 0; g < 3; g++)
		begin : g_unit
			wire ta = (g == 0) ? ch4_trigger_a    : ch7_trigger_a;    // see R4
			wire tb = (g == 0) ? ch4_trigger_b    : ch7_trigger_b;    // see R4
			wire tc = (g == 0) ? ch4_trigger_both : ch7_trigger_both;
			wire [1:0] s = src_sel[2*g +: 2];
			assign direct_hit[g] = (s == astr_pkg::ASTR_SRC_A)    ? ta
				: (s == astr_pkg::ASTR_SRC_B)    ? tb
				: (s == astr_pkg::ASTR_SRC_AORB) ? (ta | tb)
				: tc; // see R5
		end
	endgenerate

	// one registered stage gives a fixed one-cycle latency, see R10
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			link_pulse <= 6'h00;
			sync_pulse <= 3'h0;
		end
		else if (clk_en)
		begin
			link_pulse <= link_hit & {6{sync_mode}};
			sync_pulse <= direct_hit & {3{sync_mode}}; // see R1
		end
	end

	// selector order: 0..2 feed link input 0 of units 0..2, 3..5 input 1
	assign unit_sync_trigger  = sync_pulse;
	assign unit_link_trigger0 = link_pulse[2:0];
	assign unit_link_trigger1 = link_pulse[5:3];
	assign unit_start         = sync_pulse | link_pulse[2:0] | link_pulse[5:3];

	// --------------------------------------------------------------
	// elaboration checks
	// --------------------------------------------------------------
	// the last pwm code must still fit the 8-bit code field
	localparam int LAST_CODE = int'(astr_pkg::CODE_BASE_B)
		+ (astr_pkg::NUM_PWM - 1) * int'(astr_pkg::CODE_STEP);
	if (LAST_CODE > 255)
	begin : g_chk_codes
		$error("pwm event codes overflow the code field");
	end
	// request ports carry ten channels, the link has six inputs
	if (astr_pkg::NUM_PWM != 10 || astr_pkg::NUM_SEL != 6)
	begin : g_chk_counts
		$error("channel or selector count does not match the ports");
	end

	// --------------------------------------------------------------
	// assertions on the routed triggers
	// --------------------------------------------------------------
	AST_SYNC_GATE: assert property (@(posedge clk_sys) disable iff (!rstn) // see R3
		!$past(sync_mode) && $past(clk_en) |-> unit_start == 3'h0)
		else $error("trigger while not in sync mode");
	AST_DIRECT_LAT: assert property (@(posedge clk_sys) disable iff (!rstn) // see R4
		clk_en && sync_mode && ch4_trigger_a && src_sel[1:0] == 2'b00
		|=> unit_sync_trigger[0])
		else $error("channel 4 a trigger not forwarded");
	AST_DIRECT_B: assert property (@(posedge clk_sys) disable iff (!rstn) // see R4
		clk_en && sync_mode && ch4_trigger_b && src_sel[1:0] == 2'b01
		|=> unit_sync_trigger[0])
		else $error("channel 4 b trigger not forwarded");
	AST_EITHER: assert property (@(posedge clk_sys) disable iff (!rstn) // see R5
		clk_en && sync_mode && (ch7_trigger_a || ch7_trigger_b) && src_sel[5:4] == 2'b10
		|=> unit_sync_trigger[2])
		else $error("a or b trigger not forwarded");
	AST_BOTH: assert property (@(posedge clk_sys) disable iff (!rstn) // see R5
		clk_en && sync_mode && ch7_trigger_both && src_sel[3:2] == 2'b11
		|=> unit_sync_trigger[1])
		else $error("combined trigger not forwarded");
	AST_LINK_CODE: assert property (@(posedge clk_sys) disable iff (!rstn) // see R7
		clk_en && sync_mode && sel[0] == astr_pkg::CODE_BASE_B && pwm_req_b[0]
		&& !extended_skip_link_reg |=> unit_link_trigger0[0])
		else $error("code 51h did not route request b");
	AST_LINK_FIRST: assert property (@(posedge clk_sys) disable iff (!rstn) // see R7
		clk_en && sync_mode && sel[3] == astr_pkg::CODE_BASE_A && pwm_req_a[0]
		&& !extended_skip_link_reg |=> unit_link_trigger1[0])
		else $error("code 50h did not route request a");
	AST_LINK_LAST: assert property (@(posedge clk_sys) disable iff (!rstn) // see R6
		clk_en && sync_mode && sel[5] == 8'hab && pwm_req_b[9]
		&& !extended_skip_link_reg |=> unit_link_trigger1[2])
		else $error("code abh did not route channel 9 b");
	AST_SKIP_EN: assert property (@(posedge clk_sys) disable iff (!rstn) // see R9
		$past(clk_en) && $past(extended_skip_link_reg)
		&& $past(conv_request_enable_reg) == 20'h00000 |-> link_pulse == 6'h00)
		else $error("disabled request reached link");
	AST_NO_PWM_DIRECT: assert property (@(posedge clk_sys) disable iff (!rstn) // see R2
		$past(clk_en) && $past(direct_hit) == 3'h0 |-> unit_sync_trigger == 3'h0)
		else $error("sync trigger without timer source");
	AST_PULSE: assert property (@(posedge clk_sys) disable iff (!rstn) // see R10
		clk_en && unit_start[0] && !direct_hit[0] && link_hit[0] == 1'b0
		&& link_hit[3] == 1'b0 |=> !unit_start[0])
		else $error("start pulse longer than one cycle");
endmodule

// ===== hdl/astr_pkg.sv
// constants shared by the converter start trigger router
// assumes one peripheral clock for timers, link and converters
//
// Contract
// R1: multifunction timer triggers go straight to converters
// R2: pwm timer requests reach converters via link only
// R3: software sets start enable one, async select zero
// R4: channel 4/7 compare a/b matches raise a/b triggers
// R5: converter accepts a or b; both trigger combined
// R6: six 8-bit selectors, two link inputs per unit
// R7: pwm codes 50h/51h plus 0ah per channel
// R8: trigger spacing not below scan conversion time
// R9: skipped link requests need their enable bit set
// R10: routed triggers are one-cycle pulses, fixed latency
package astr_pkg;
	// --------------------------------------------------------------
	// register map, byte addresses
	// --------------------------------------------------------------
	localparam logic [11:0] ADDR_SEL0     = 12'h000; // selectors 0..5 at 0x00..0x14
	localparam logic [11:0] ADDR_CONV_CTL = 12'h018;
	localparam logic [11:0] ADDR_REQ_EN   = 12'h01c;
	localparam logic [11:0] ADDR_SKIP     = 12'h020;
	localparam logic [11:0] ADDR_SRC_SEL  = 12'h024;
	localparam logic [11:0] ADDR_STATUS   = 12'h028;
	localparam int          NUM_SEL       = 6;
	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int          CTL_START_BIT = 0;   // trigger_start_enable
	localparam int          CTL_ASYNC_BIT = 1;   // async_trigger_select
	localparam logic [7:0]  SEL_RESET     = 8'h00;
	localparam logic [1:0]  CTL_RESET     = 2'h0;
	localparam logic [19:0] REQ_EN_RESET  = 20'h00000;
	localparam logic        SKIP_RESET    = 1'b0;
	localparam logic [5:0]  SRC_SEL_RESET = 6'h00;
	// --------------------------------------------------------------
	// event codes of pwm timer requests
	// --------------------------------------------------------------
	localparam logic [7:0]  CODE_BASE_A   = 8'h50;
	localparam logic [7:0]  CODE_BASE_B   = 8'h51;
	localparam logic [7:0]  CODE_STEP     = 8'h0a;
	localparam int          NUM_PWM       = 10;
	// multifunction source select per unit: 0 a,1 b,2 a or b,3 both
	typedef enum logic [1:0]
	{
		ASTR_SRC_A    = 2'b00,
		ASTR_SRC_B    = 2'b01,
		ASTR_SRC_AORB = 2'b10,
		ASTR_SRC_BOTH = 2'b11
	} astr_src_t;
endpackage

// ===== test/astr_conv_model.sv
// converter units model: counts start pulses on the three units
// assumes unit_start pulses are sampled on clk_sys
`timescale 1ns/1ps
module astr_conv_model
#(
	parameter int SCAN_CYCLES = 2
)
(
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic [2:0] unit_start,
	output int              starts,
	output int              gap_err
);
	int since [3];
	// count starts and flag starts closer than the scan time
	always @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			starts = 0;
			gap_err = 0;
			since = '{SCAN_CYCLES, SCAN_CYCLES, SCAN_CYCLES};
		end
		else
			for (int u = 0; u < 3; u++)
			begin
				starts += unit_start[u];
				if (unit_start[u] && since[u] < SCAN_CYCLES)
					gap_err++;
				since[u] = unit_start[u] ? 1 : since[u] + 1;
			end
endmodule

// ===== test/test_adc_start_trigger_routing.sv
// bench for the trigger router: apb master, random triggers, reference model
// assumes one cycle trigger latency; the apb master waits for pready
`timescale 1ns/1ps
module test_adc_start_trigger_routing;
	logic        clk_sys = 0, rstn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h00017b8f; // xorshift start 97167
	logic        pready, pslverr, err, skip = 0, ctl_on = 0;
	logic [2:0]  c4 = 3'h0, c7 = 3'h0, sync_o, lk0, lk1, start_o;
	logic [9:0]  ra = 10'h000, rb = 10'h000;
	logic [7:0]  code [6];
	logic [19:0] en;
	logic [1:0]  mode;
	int          starts, gap_err, num_errors = 0, check_count = 0, cyc = 0, exp_st = 0;
	astr_router dut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ch4_trigger_a(c4[0]),
		.ch4_trigger_b(c4[1]), .ch4_trigger_both(c4[2]), .ch7_trigger_a(c7[0]),
		.ch7_trigger_b(c7[1]), .ch7_trigger_both(c7[2]), .pwm_req_a(ra), .pwm_req_b(rb),
		.unit_sync_trigger(sync_o), .unit_link_trigger0(lk0), .unit_link_trigger1(lk1),
		.unit_start(start_o));
	astr_conv_model conv (.clk_sys(clk_sys), .rstn(rstn), .unit_start(start_o),
		.starts(starts), .gap_err(gap_err));
	// --------------------------------------------------------------
	// clock, timeout and helpers
	// --------------------------------------------------------------
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			tally_and_finish();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic tally_and_finish();
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(logic [32:0] got, logic [32:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// --------------------------------------------------------------
	// reference model of both trigger paths
	// --------------------------------------------------------------
	function automatic logic src(logic [2:0] t);
		case (mode)
			2'd0: return t[0];
			2'd1: return t[1];
			2'd2: return t[0] | t[1];
			default: return t[2];
		endcase
	endfunction
	function automatic logic hit(logic [7:0] k, logic [9:0] a, logic [9:0] b);
		for (int c = 0; c < 10; c++)
			if ((k == 80 + 10 * c && a[c] && (!skip || en[c]))
				|| (k == 81 + 10 * c && b[c] && (!skip || en[10 + c])))
				return 1;
		return 0;
	endfunction
	// one random trigger cycle, result one cycle later, then idle
	// triggers stay three cycles apart, above the scan time
	task automatic pulse();
		logic [2:0] t4, t7, es, e0, e1;
		logic [9:0] a, b;
		t4 = 3'(rnd());
		t7 = 3'(rnd());
		a = 10'(rnd());
		b = 10'(rnd());
		@(posedge clk_sys);
		c4 <= t4;
		c7 <= t7;
		ra <= a;
		rb <= b;
		@(posedge clk_sys);
		c4 <= 0;
		c7 <= 0;
		ra <= 0;
		rb <= 0;
		#1;
		for (int u = 0; u < 3; u++)
		begin
			es[u] = ctl_on & src(u == 0 ? t4 : t7);
			e0[u] = ctl_on & hit(code[u], a, b);
			e1[u] = ctl_on & hit(code[u + 3], a, b);
		end
		chk(sync_o, es);
		chk({lk1, lk0}, {e1, e0});
		chk(start_o, es | e0 | e1);
		exp_st += $countones(es | e0 | e1);
		@(posedge clk_sys);
		#1 chk(start_o, 3'h0);
	endtask
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rstn <= 1;
		for (int k = 0; k < 6; k++)
		begin
			apb(0, astr_pkg::ADDR_SEL0 + 12'(4 * k), 0);
			chk(rd[7:0], astr_pkg::SEL_RESET);
		end
		apb(0, astr_pkg::ADDR_CONV_CTL, 0);
		chk(rd[1:0], astr_pkg::CTL_RESET);
		apb(0, 12'h02c, 0);
		chk({err, rd}, {1'b1, 32'h0});
		for (int p = 0; p < 8; p++)
		begin
			mode = 2'(p % 4);
			skip = p > 5;
			// last phase: skipping on with every request disabled
			en = p == 7 ? 20'h00000 : 20'(rnd());
			apb(1, astr_pkg::ADDR_SRC_SEL, {26'h0, mode, mode, mode});
			apb(1, astr_pkg::ADDR_REQ_EN, {12'h0, en});
			apb(1, astr_pkg::ADDR_SKIP, {31'h0, skip});
			apb(0, astr_pkg::ADDR_SRC_SEL, 0);
			chk(rd[5:0], {mode, mode, mode});
			apb(0, astr_pkg::ADDR_REQ_EN, 0);
			chk(rd[19:0], en);
			apb(0, astr_pkg::ADDR_SKIP, 0);
			chk(rd[0], skip);
			for (int k = 0; k < 6; k++)
			begin
				code[k] = rnd() % 11 == 10 ? 8'hff : 8'(80 + 10 * (rnd() % 10) + rnd() % 2);
				// one phase pins the first and last codes of the table
				if (p == 5)
					code[k] = k == 0 ? 8'h51 : k == 3 ? 8'h50 : k == 5 ? 8'hab : code[k];
				apb(1, astr_pkg::ADDR_SEL0 + 12'(4 * k), {24'h0, code[k]});
			end
			ctl_on = p > 1;
			apb(1, astr_pkg::ADDR_CONV_CTL, p == 0 ? 32'h0 : p == 1 ? 32'h3 : 32'h1);
			clk_en <= 0;
			apb(1, astr_pkg::ADDR_CONV_CTL, 32'h0);
			clk_en <= 1;
			apb(0, astr_pkg::ADDR_STATUS, 0);
			chk(rd[9], ctl_on);
			chk(rd[8:0], 9'h000);
			repeat (8) pulse();
		end
		chk(starts, exp_st);
		chk(gap_err, 0);
		tally_and_finish();
	end
endmodule
